/* File: inc/fipc_pkg.sv */
// constants and types for the failsafe interrupt dispatch block
`default_nettype none
package fipc_pkg;
    localparam int ASYNC_N = 4;
    localparam int ONBOARD_N = 16;
    localparam int SYNC_N = ONBOARD_N + ASYNC_N;
    localparam logic [ASYNC_N-1:0] ASYNC_CFG_RST = 4'hf;
    localparam logic [SYNC_N-1:0] SYNC_CFG_RST = 20'h00000;
    localparam logic [1:0] LEVEL_CYCLIC = 2'h0;
    localparam logic [1:0] LEVEL_TIMED = 2'h1;
    localparam logic [1:0] LEVEL_SYNC = 2'h2;
    localparam logic [1:0] LEVEL_ASYNC = 2'h3;
    typedef enum logic [1:0] {
        FIPC_RUN_BASE,
        FIPC_RUN_SYNC,
        FIPC_RUN_ASYNC
    } fipc_state_e;
endpackage : fipc_pkg
`default_nettype wire

/* File: rtl/fipc_edge.sv */
// synchroniser and falling-edge detector for the interrupt inputs
`default_nettype none
module fipc_edge #(
    parameter int WIDTH = 4
) (
    input wire logic CLOCK,
    input wire logic ARST_N,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] sync_a;
    logic [WIDTH-1:0] sync_b;
    logic [WIDTH-1:0] prev;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge CLOCK or negedge ARST_N) begin
                if (!ARST_N) begin
                    sync_a[i] <= 1'b1;
                    sync_b[i] <= 1'b1;
                    prev[i] <= 1'b1;
                end else begin
                    sync_a[i] <= pin_in[i];
                    sync_b[i] <= sync_a[i];
                    prev[i] <= sync_b[i];
                end
            end
            // one pulse per falling edge
            assign fall[i] = prev[i] & ~sync_b[i]; // see R12
        end
    endgenerate
endmodule : fipc_edge
`default_nettype wire

/* File: rtl/fipc_ctrl.sv */
// interrupt dispatch: edge capture, pending, priority and resume tracking
`default_nettype none
// How it works
// R1: falling edge on async input requests async level
// R2: subunit launches async alone, no partner check
// R3: four async and twenty sync sources configurable
// R4: sync sources: sixteen onboard plus four special
// R5: fixed priority async, sync, timed, cyclic
// R6: qualifying edge suspends running program, starts routine
// R7: resume exactly at interrupted point after routine
// R8: only configured inputs raise a level
// R9: async requests during async routine latched, re-entered
// R10: disable blocks dispatch, enable restores, pending kept
// R11: diag bit set per async edge, even uninstalled; code sets it only for async inputs enabled in ASYNC_CFG
// R12: inputs synchronised, one pulse per falling edge
// R13: pending cleared when routine start acknowledged
module fipc_ctrl
    import fipc_pkg::*;
(
    input wire logic CLOCK,
    input wire logic ARST_N,
    input wire logic [ASYNC_N-1:0] ASYNC_IRQ_IN,
    input wire logic [ONBOARD_N-1:0] ONBOARD_IN,
    input wire logic [ASYNC_N-1:0] ASYNC_CFG,
    input wire logic [SYNC_N-1:0] SYNC_CFG,
    input wire logic ASYNC_ROUTINE_INSTALLED,
    input wire logic SYNC_PARTNER_SEEN,
    input wire logic IRQ_DISABLE_OP,
    input wire logic IRQ_ENABLE_OP,
    input wire logic TIMED_ACTIVE,
    input wire logic START_ACK,
    input wire logic ROUTINE_DONE,
    input wire logic [ASYNC_N-1:0] DIAG_CLEAR,
    input wire logic [ASYNC_N-1:0] SYNC_CAUSE_CLEAR,
    output logic START_ASYNC_REQ,
    output logic START_SYNC_REQ,
    output logic SUSPEND,
    output logic RESUME,
    output logic [1:0] ACTIVE_LEVEL,
    output logic [1:0] RESUME_LEVEL,
    output logic [ASYNC_N-1:0] IRQ_DIAG_BYTE,
    output logic [SYNC_N-1:0] SYNC_CAUSE,
    output logic IRQ_ENABLED,
    output logic ASYNC_PENDING,
    output logic SYNC_PENDING
);
    logic [SYNC_N-1:0] fall;
    logic [ASYNC_N-1:0] async_hit;
    logic [SYNC_N-1:0] sync_hit;
    logic async_ev;
    logic async_ack;
    logic sync_ack;
    logic [1:0] base_level;
    logic [1:0] saved_level;
    logic saved_valid;
    fipc_state_e state;
    fipc_state_e next_state;

    // special inputs occupy the top four sync positions
    fipc_edge #(.WIDTH(SYNC_N)) u_edge (
        .CLOCK(CLOCK),
        .ARST_N(ARST_N),
        .pin_in({ASYNC_IRQ_IN, ONBOARD_IN}), // see R4
        .fall(fall)
    );

    assign async_hit = fall[SYNC_N-1:ONBOARD_N] & ASYNC_CFG; // see R1, R3, R8
    assign sync_hit = fall & SYNC_CFG; // see R3, R4, R8
    assign async_ev = |async_hit;
    // own edge only; no partner agreement needed
    assign async_ack = START_ACK && START_ASYNC_REQ; // see R2
    assign sync_ack = START_ACK && START_SYNC_REQ;

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            IRQ_ENABLED <= 1'b1;
        end else if (IRQ_DISABLE_OP) begin
            IRQ_ENABLED <= 1'b0; // see R10
        end else if (IRQ_ENABLE_OP) begin
            IRQ_ENABLED <= 1'b1; // see R10
        end
    end

    // installed routine needed for a start; otherwise only diag bit
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            ASYNC_PENDING <= 1'b0;
        end else if (async_ev && ASYNC_ROUTINE_INSTALLED) begin
            ASYNC_PENDING <= 1'b1; // see R9, R10
        end else if (async_ack) begin
            ASYNC_PENDING <= 1'b0; // see R13
        end
    end

    // own edge sets pending; the start itself waits for the partner
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            SYNC_PENDING <= 1'b0;
        end else if (|sync_hit) begin
            SYNC_PENDING <= 1'b1; // see R10
        end else if (sync_ack) begin
            SYNC_PENDING <= 1'b0; // see R13
        end
    end

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            SYNC_CAUSE <= SYNC_CFG_RST;
        end else begin
            SYNC_CAUSE <= (SYNC_CAUSE & ~{SYNC_CAUSE_CLEAR, {ONBOARD_N{1'b0}}}) | sync_hit;
        end
    end

    // set wins over software clear
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            IRQ_DIAG_BYTE <= '0;
        end else begin
            IRQ_DIAG_BYTE <= (IRQ_DIAG_BYTE & ~DIAG_CLEAR) | async_hit; // see R11
        end
    end

    assign base_level = TIMED_ACTIVE ? LEVEL_TIMED : LEVEL_CYCLIC;

    // fixed priority grant; async never pre-empted
    always_comb begin
        next_state = state;
        unique case (state)
            FIPC_RUN_BASE: begin
                if (async_ack) begin
                    next_state = FIPC_RUN_ASYNC; // see R5, R6
                end else if (sync_ack) begin
                    next_state = FIPC_RUN_SYNC; // see R6
                end
            end
            FIPC_RUN_SYNC: begin
                if (async_ack) begin
                    next_state = FIPC_RUN_ASYNC; // see R5
                end else if (ROUTINE_DONE) begin
                    next_state = FIPC_RUN_BASE;
                end
            end
            FIPC_RUN_ASYNC: begin
                if (ROUTINE_DONE) begin
                    next_state = saved_valid ? FIPC_RUN_SYNC : FIPC_RUN_BASE; // see R7
                end
            end
            default: next_state = FIPC_RUN_BASE;
        endcase
    end

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            state <= FIPC_RUN_BASE;
        end else begin
            state <= next_state;
        end
    end

    // remember sync as return point when async pre-empts it
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            saved_valid <= 1'b0;
        end else if (state == FIPC_RUN_SYNC && async_ack) begin
            saved_valid <= 1'b1; // see R7
        end else if (state == FIPC_RUN_ASYNC && ROUTINE_DONE) begin
            saved_valid <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            saved_level <= LEVEL_CYCLIC;
        end else if (state == FIPC_RUN_BASE && (async_ack || sync_ack)) begin
            saved_level <= base_level; // see R7
        end
    end

    // requests: async may start anywhere but inside async
    assign START_ASYNC_REQ = IRQ_ENABLED && ASYNC_PENDING && state != FIPC_RUN_ASYNC; // see R5, R9, R10
    assign START_SYNC_REQ = IRQ_ENABLED && SYNC_PENDING && !ASYNC_PENDING
                            && state == FIPC_RUN_BASE && SYNC_PARTNER_SEEN; // see R5, R10

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            SUSPEND <= 1'b0;
        end else begin
            SUSPEND <= async_ack || sync_ack; // see R6
        end
    end

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            RESUME <= 1'b0;
        end else begin
            RESUME <= ROUTINE_DONE && state != FIPC_RUN_BASE; // see R7
        end
    end

    // level shown follows the state being entered
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            ACTIVE_LEVEL <= LEVEL_CYCLIC;
        end else begin
            unique case (next_state)
                FIPC_RUN_ASYNC: ACTIVE_LEVEL <= LEVEL_ASYNC; // see R5
                FIPC_RUN_SYNC: ACTIVE_LEVEL <= LEVEL_SYNC;
                default: ACTIVE_LEVEL <= base_level;
            endcase
        end
    end

    // return point reported with each resume
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            RESUME_LEVEL <= LEVEL_CYCLIC;
        end else if (ROUTINE_DONE && state == FIPC_RUN_ASYNC && saved_valid) begin
            RESUME_LEVEL <= LEVEL_SYNC; // see R7
        end else if (ROUTINE_DONE && state != FIPC_RUN_BASE) begin
            RESUME_LEVEL <= saved_level; // see R7
        end
    end
endmodule : fipc_ctrl
`default_nettype wire

/* File: sim/fipc_ctrl_monitor.sv */
// assertions on the dispatch block ports
`default_nettype none
module fipc_monitor
    import fipc_pkg::*;
(
    input wire logic CLOCK,
    input wire logic ARST_N,
    input wire logic START_ACK,
    input wire logic ROUTINE_DONE,
    input wire logic IRQ_DISABLE_OP,
    input wire logic START_ASYNC_REQ,
    input wire logic START_SYNC_REQ,
    input wire logic SUSPEND,
    input wire logic RESUME,
    input wire logic [1:0] ACTIVE_LEVEL,
    input wire logic IRQ_ENABLED,
    input wire logic ASYNC_PENDING
);
    timeunit 1ns / 100ps;
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!ARST_N);
    AST_ACK_SUSPEND: assert property (START_ACK |=> SUSPEND ##1 !SUSPEND)
        else $error("suspend not a single pulse after start");
    AST_ASYNC_START: assert property (START_ACK && START_ASYNC_REQ |=> ACTIVE_LEVEL == LEVEL_ASYNC && !ASYNC_PENDING)
        else $error("async start wrong");
    AST_ASYNC_HELD: assert property (ACTIVE_LEVEL == LEVEL_ASYNC && !ROUTINE_DONE |=> ACTIVE_LEVEL == LEVEL_ASYNC)
        else $error("async routine left early");
    AST_DONE_RESUME: assert property (ROUTINE_DONE && ACTIVE_LEVEL[1] |=> RESUME ##1 !RESUME)
        else $error("resume not a single pulse after done");
    AST_SYNC_YIELD: assert property (START_ASYNC_REQ |-> !START_SYNC_REQ)
        else $error("sync request beside async");
    AST_DISABLED: assert property (!IRQ_ENABLED |-> !START_ASYNC_REQ && !START_SYNC_REQ)
        else $error("request while disabled");
    AST_DISABLE_OP: assert property (IRQ_DISABLE_OP |=> !IRQ_ENABLED)
        else $error("disable ignored");
    AST_REQ_STANDS: assert property (START_ASYNC_REQ && !START_ACK && !IRQ_DISABLE_OP |=> START_ASYNC_REQ)
        else $error("async request dropped");
endmodule : fipc_monitor
bind fipc_ctrl fipc_monitor fipc_monitor_inst (.CLOCK(CLOCK), .ARST_N(ARST_N), .START_ACK(START_ACK),
    .ROUTINE_DONE(ROUTINE_DONE), .IRQ_DISABLE_OP(IRQ_DISABLE_OP), .START_ASYNC_REQ(START_ASYNC_REQ),
    .START_SYNC_REQ(START_SYNC_REQ), .SUSPEND(SUSPEND), .RESUME(RESUME), .ACTIVE_LEVEL(ACTIVE_LEVEL),
    .IRQ_ENABLED(IRQ_ENABLED), .ASYNC_PENDING(ASYNC_PENDING));
`default_nettype wire

/* File: sim/fipc_sensor.sv */
// process sensors driving the pins, idle high
`default_nettype none
module fipc_sensor (
    input wire logic clock,
    output logic [19:0] pins
);
    timeunit 1ns / 100ps;
    initial pins = 20'hfffff;
    task fall(input int i);
        pins[i] = 1'b0;
        repeat (3) @(posedge clock);
        #1 pins[i] = 1'b1;
    endtask : fall
endmodule : fipc_sensor
`default_nettype wire

/* File: sim/failsafe_irq_priority_ctrl_bench.sv */
// self-checking bench for the dispatch block
`default_nettype none
module failsafe_irq_priority_ctrl_bench import fipc_pkg::*; ;
    timeunit 1ns / 100ps;
    logic clock = 0, arst_n = 0, inst = 1, partner = 0, dis = 0, ena = 0, timed = 0, ack = 0, done = 0;
    logic [3:0] acfg = 4'hf, dclr = 4'h0, cclr = 4'h0, diag;
    logic [19:0] scfg = 20'h00001, cause;
    wire logic [19:0] pins;
    logic sar, ssr, sus, res, en, ap, sp;
    logic [1:0] al, rl;
    int errors = 0, samples_checked = 0;
    logic [3:0] rows [6] = '{4'hc, 4'hd, 4'he, 4'hf, 4'h4, 4'h8};
    fipc_sensor fipc_sensor_inst (.clock(clock), .pins(pins));
    fipc_ctrl fipc_ctrl_inst (.CLOCK(clock), .ARST_N(arst_n), .ASYNC_IRQ_IN(pins[19:16]), .ONBOARD_IN(pins[15:0]),
        .ASYNC_CFG(acfg), .SYNC_CFG(scfg), .ASYNC_ROUTINE_INSTALLED(inst), .SYNC_PARTNER_SEEN(partner),
        .IRQ_DISABLE_OP(dis), .IRQ_ENABLE_OP(ena), .TIMED_ACTIVE(timed), .START_ACK(ack), .ROUTINE_DONE(done),
        .DIAG_CLEAR(dclr), .SYNC_CAUSE_CLEAR(cclr), .START_ASYNC_REQ(sar), .START_SYNC_REQ(ssr), .SUSPEND(sus),
        .RESUME(res), .ACTIVE_LEVEL(al), .RESUME_LEVEL(rl), .IRQ_DIAG_BYTE(diag), .SYNC_CAUSE(cause),
        .IRQ_ENABLED(en), .ASYNC_PENDING(ap), .SYNC_PENDING(sp));
    initial forever #5 clock = ~clock;
    initial begin
        #20us;
        errors++;
        close_out;
    end
    task cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc
    task chk(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("FAIL %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task start(input logic [1:0] lev);
        ack = 1;
        cyc(1);
        ack = 0;
        chk({sus, al}, {1'b1, lev});
    endtask : start
    task finish(input logic [1:0] back);
        done = 1;
        cyc(1);
        done = 0;
        chk({res, al, rl}, {1'b1, back, back});
    endtask : finish
    task close_out;
        if (errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out
    initial begin
        cyc(5);
        chk({en, al, diag}, {1'b1, LEVEL_CYCLIC, 4'h0});
        arst_n = 1;
        foreach (rows[r]) begin
            acfg = {4{rows[r][3]}};
            inst = rows[r][2];
            fipc_sensor_inst.fall(16 + rows[r][1:0]);
            cyc(3);
            chk({diag, sar}, {4'(rows[r][3]) << rows[r][1:0], rows[r][3] & rows[r][2]});
            if (sar === 1'b1) begin
                start(LEVEL_ASYNC);
                finish(LEVEL_CYCLIC);
            end
            dclr = 4'hf;
            cyc(1);
            dclr = 4'h0;
        end
        acfg = 4'hf;
        inst = 1;
        fipc_sensor_inst.fall(16);
        cyc(3);
        start(LEVEL_ASYNC);
        fipc_sensor_inst.fall(17);
        cyc(3);
        chk({ap, sar}, 2'b10);
        finish(LEVEL_CYCLIC);
        chk(sar, 1'b1);
        start(LEVEL_ASYNC);
        finish(LEVEL_CYCLIC);
        dis = 1;
        cyc(1);
        dis = 0;
        fipc_sensor_inst.fall(18);
        cyc(3);
        chk({en, sar, ap}, 3'b001);
        ena = 1;
        cyc(1);
        ena = 0;
        chk(sar, 1'b1);
        start(LEVEL_ASYNC);
        finish(LEVEL_CYCLIC);
        timed = 1;
        fipc_sensor_inst.fall(0);
        cyc(3);
        chk({ssr, cause[0]}, 2'b01);
        partner = 1;
        cyc(1);
        chk(ssr, 1'b1);
        start(LEVEL_SYNC);
        fipc_sensor_inst.fall(16);
        cyc(3);
        chk(sar, 1'b1);
        start(LEVEL_ASYNC);
        finish(LEVEL_SYNC);
        cyc(1);
        finish(LEVEL_TIMED);
        acfg = 4'h0;
        scfg = 20'h10001;
        fipc_sensor_inst.fall(16);
        cyc(3);
        chk({sp, ssr, cause[16], ap}, 4'b1110);
        start(LEVEL_SYNC);
        chk(sp, 1'b0);
        finish(LEVEL_TIMED);
        cclr = 4'h1;
        cyc(1);
        cclr = 4'h0;
        chk(cause[16], 1'b0);
        arst_n = 0;
        cyc(1);
        chk({en, al, diag}, {1'b1, LEVEL_CYCLIC, 4'h0});
        close_out;
    end
endmodule : failsafe_irq_priority_ctrl_bench
`default_nettype wire
